// ==== pkg/dht_pkg.sv ====
// Package for the dual half timer: modes, interrupt bit layout and port carriers.
// Assumes one 50 MHz clock and a synchronous active-low reset in every user.
package dht_pkg;

  // Clock period in nanoseconds.
  localparam int CLOCK_PERIOD_NS = 20;

  // Widths of one half and of the combined timer, and the number of interrupt sources.
  localparam int HALF_WIDTH = 16;
  localparam int WIDE_WIDTH = 32;
  localparam int IRQ_COUNT  = 7;

  // Interrupt bit layout: each half owns a group of bits starting at its base.
  localparam int IRQ_HALF_STRIDE    = 4;
  localparam int IRQ_TIMEOUT_OFS    = 0;
  localparam int IRQ_CAP_MATCH_OFS  = 1;
  localparam int IRQ_CAP_EVENT_OFS  = 2;
  localparam int IRQ_RTC_MATCH_BIT  = 3;

  // Value masks for a single half and for the combined timer.
  localparam logic [31:0] HALF_MASK = 32'h0000FFFF;
  localparam logic [31:0] WIDE_MASK = 32'hFFFFFFFF;

  // Whole-block configuration.
  typedef enum logic [1:0] {
    DHT_PAIR    = 2'h0,
    DHT_W32_OS  = 2'h1,
    DHT_W32_PER = 2'h2,
    DHT_W32_RTC = 2'h3
  } dht_global_type;

  // Behaviour of one half; the last code can be set directly and is also forced on the first half by the combined clock setting.
  typedef enum logic [2:0] {
    DHT_ONE_SHOT  = 3'h0,
    DHT_PERIODIC  = 3'h1,
    DHT_CAP_COUNT = 3'h2,
    DHT_CAP_TIME  = 3'h3,
    DHT_PWM       = 3'h4,
    DHT_RTC       = 3'h5
  } dht_half_mode_type;

  // Static control levels from the software side.
  typedef struct packed {
    dht_global_type                global_mode;
    dht_half_mode_type [1:0]       half_mode;
    logic [1:0]                    enable;
    logic                          rtc_enable;
    logic [1:0]                    output_polarity_low;
    logic [1:0]                    halt_in_debug;
    logic [1:0]                    trigger_out_on;
    logic [IRQ_COUNT-1:0]          irq_enable;
    logic                          masked_view_select;
  } dht_ctrl_type;

  // One-cycle write strobes with their shared data word.
  typedef struct packed {
    logic [1:0]                    load_wr;
    logic [1:0]                    match_wr;
    logic                          clear_wr;
    logic [IRQ_COUNT-1:0]          irq_source_mask;
    logic [31:0]                   wdata;
  } dht_write_type;

endpackage

// ==== hdl/dht_timer.sv ====
// Dual half timer with debug stall, polarity, trigger and interrupt status logic.
// Assumes all inputs are synchronous to clock; write strobes last one cycle.
//
// Summary of operation
// - PWM output active low when polarity set
// - Halt-in-debug freezes that half's counter
// - Trigger pulse only when trigger enabled
// - Only enabled sources reach the interrupt line
// - Seven sources, each a distinct mask bit
// - Raw or masked status, same bit positions
// - Clear mask clears only indicated sources
// - Halves start and stop independently
// - Load write while running reloads counter
// - Combined mode uses only first half registers
// - Load value readable apart from counter
// - Two 16-bit halves or one 32-bit timer
// - One-shot stops at zero, periodic reloads
// - Match sets capture threshold and PWM duty
`timescale 1ns/1ps
module dht_timer
  import dht_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire dht_pkg::dht_ctrl_type      ctrl,
  input  wire dht_pkg::dht_write_type     wr,
  input  wire logic                       debug_halted,
  input  wire logic [1:0]                 cap_in,
  input  wire logic                       rtc_tick,
  output      logic                       irq,
  output      logic [dht_pkg::IRQ_COUNT-1:0] status_view,
  output      logic [1:0][31:0]           timer_value,
  output      logic [1:0][31:0]           load_readback,
  output      logic [1:0]                 pwm_out,
  output      logic [1:0]                 trigger_out
);
  import dht_pkg::*;

  // Complete state of the block.
  typedef struct packed {
    logic [1:0][31:0]     cnt;
    logic [1:0][31:0]     load;
    logic [1:0][31:0]     match;
    logic [IRQ_COUNT-1:0] raw;
    logic [IRQ_COUNT-1:0] status;
    logic [1:0]           done;
    logic [1:0]           en_prev;
    logic [1:0]           cap_prev;
    logic [1:0]           pwm;
    logic [1:0]           trig;
  } dht_state_type;

  localparam dht_state_type STATE_RESET = '0;

  dht_state_type        s;
  dht_state_type        next_s;
  logic [IRQ_COUNT-1:0] irq_set;

  // Effective behaviour of a half once the combined setting is taken into account.
  function automatic dht_half_mode_type eff_mode(input dht_global_type g,
                                                 input dht_half_mode_type m);
    case (g)
      DHT_W32_OS:  eff_mode = DHT_ONE_SHOT;
      DHT_W32_PER: eff_mode = DHT_PERIODIC;
      DHT_W32_RTC: eff_mode = DHT_RTC;
      default:     eff_mode = m;
    endcase
  endfunction

  // Bit position of a per-half interrupt source.
  function automatic int irq_pos(input int h, input int ofs);
    irq_pos = h * IRQ_HALF_STRIDE + ofs;
  endfunction

  // Next-state logic for both halves and the shared status.
  always_comb
  begin
    logic              wide;
    logic              used;
    logic              go;
    logic              edge_seen;
    logic [31:0]       msk;
    logic [31:0]       reload;
    dht_half_mode_type kind;
    wide      = 1'b0;
    used      = 1'b0;
    go        = 1'b0;
    edge_seen = 1'b0;
    msk       = HALF_MASK;
    reload    = '0;
    kind      = DHT_ONE_SHOT;
    next_s    = s;
    irq_set   = '0;
    next_s.trig     = '0;
    next_s.en_prev  = ctrl.enable;
    next_s.cap_prev = cap_in;
    for (int h = 0; h < 2; h++)
    begin
      // The second half sits idle when the halves are combined.
      wide = (h == 0) && (ctrl.global_mode != DHT_PAIR);
      used = (h == 0) || (ctrl.global_mode == DHT_PAIR);
      msk  = wide ? WIDE_MASK : HALF_MASK;
      kind = eff_mode(ctrl.global_mode, ctrl.half_mode[h]);
      // A disabled half or a stalled half under debug does not move.
      go = used && ctrl.enable[h] && !s.done[h]
           && !(ctrl.halt_in_debug[h] && debug_halted);
      edge_seen = cap_in[h] && !s.cap_prev[h];
      reload = (s.cnt[h] == '0) ? s.load[h] : ((s.cnt[h] - 32'h00000001) & msk);
      if (used && ctrl.enable[h] && !s.en_prev[h])
      begin
        next_s.cnt[h]  = s.load[h];
        next_s.done[h] = 1'b0;
      end
      else if (!ctrl.enable[h])
      begin
        next_s.done[h] = 1'b0;
      end
      else if (go)
      begin
        case (kind)
          DHT_ONE_SHOT, DHT_PERIODIC:
          begin
            next_s.cnt[h] = reload;
            if (s.cnt[h] == '0)
            begin
              irq_set[irq_pos(h, IRQ_TIMEOUT_OFS)] = 1'b1;
              next_s.trig[h] = ctrl.trigger_out_on[h];
              if (kind == DHT_ONE_SHOT)
              begin
                next_s.cnt[h]  = '0;
                next_s.done[h] = 1'b1;
              end
            end
          end
          DHT_CAP_COUNT:
          begin
            // Each edge counts down; reaching the match value interrupts.
            if (edge_seen)
            begin
              next_s.cnt[h] = reload;
              if (reload == s.match[h])
              begin
                irq_set[irq_pos(h, IRQ_CAP_MATCH_OFS)] = 1'b1;
                next_s.trig[h] = ctrl.trigger_out_on[h];
              end
            end
          end
          DHT_CAP_TIME:
          begin
            next_s.cnt[h] = reload;
            if (edge_seen)
            begin
              irq_set[irq_pos(h, IRQ_CAP_EVENT_OFS)] = 1'b1;
              next_s.trig[h] = ctrl.trigger_out_on[h];
            end
          end
          DHT_PWM:
          begin
            next_s.cnt[h] = reload;
            if (s.cnt[h] == '0)
            begin
              next_s.trig[h] = ctrl.trigger_out_on[h];
            end
          end
          DHT_RTC:
          begin
            // Seconds count upward only while the clock function is enabled.
            if (ctrl.rtc_enable && rtc_tick)
            begin
              next_s.cnt[h] = s.cnt[h] + 32'h00000001;
              if ((s.cnt[h] + 32'h00000001) == s.match[h])
              begin
                irq_set[IRQ_RTC_MATCH_BIT] = 1'b1;
                next_s.trig[h] = ctrl.trigger_out_on[h];
              end
            end
          end
          default:
          begin
            next_s.cnt[h] = s.cnt[h];
          end
        endcase
      end
      // A load write reaches the counter at once when the half runs.
      if (used && wr.load_wr[h])
      begin
        next_s.load[h] = wr.wdata & msk;
        if (ctrl.enable[h])
        begin
          next_s.cnt[h]  = wr.wdata & msk;
          next_s.done[h] = 1'b0;
        end
      end
      if (used && wr.match_wr[h])
      begin
        next_s.match[h] = wr.wdata & msk;
      end
      // Edge-aligned pulse above the match level, flipped by polarity.
      next_s.pwm[h] = ((kind == DHT_PWM) && (s.cnt[h] > s.match[h]))
                      ^ ctrl.output_polarity_low[h];
    end
    // A new event wins over a clear arriving in the same cycle.
    next_s.raw = (s.raw & ~(wr.clear_wr ? wr.irq_source_mask : '0)) | irq_set;
    // Both views share the same bit positions.
    next_s.status = ctrl.masked_view_select ? (s.raw & ctrl.irq_enable) : s.raw;
  end

  // Single state register; everything returns to zero on reset.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s <= STATE_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs come straight from state; the line is the OR of enabled sources.
  assign irq           = |(s.raw & ctrl.irq_enable);
  assign status_view   = s.status;
  assign timer_value   = s.cnt;
  assign load_readback = s.load;
  assign pwm_out       = s.pwm;
  assign trigger_out   = s.trig;

  // The masked view lands one cycle after the line that it mirrors.
  AST_IRQ_LINE: assert property (@(posedge clock) disable iff (!reset_n)
    ctrl.masked_view_select |=> ((|status_view) == $past(irq)))
    else $error("Interrupt line disagrees with masked status.");

  // A disabled source never raises the line on its own.
  AST_MASK_GATES: assert property (@(posedge clock) disable iff (!reset_n)
    (ctrl.irq_enable == '0) |-> !irq)
    else $error("Disabled sources raised the interrupt line.");

  // A full clear with no new event leaves nothing pending.
  AST_CLEAR_ALL: assert property (@(posedge clock) disable iff (!reset_n)
    (wr.clear_wr && (wr.irq_source_mask == 7'h7F) && (irq_set == '0)) |=> (s.raw == '0))
    else $error("Cleared sources are still pending.");

  // A new event survives a clear in the same cycle.
  AST_SET_WINS: assert property (@(posedge clock) disable iff (!reset_n)
    (irq_set[0] && wr.clear_wr && wr.irq_source_mask[0]) |=> s.raw[0])
    else $error("Event lost against a simultaneous clear.");

  // Masked view equals raw AND enables one cycle later.
  AST_MASKED_VIEW: assert property (@(posedge clock) disable iff (!reset_n)
    ctrl.masked_view_select |=> (status_view == $past(s.raw & ctrl.irq_enable)))
    else $error("Masked status view is wrong.");

  // A disabled first half holds its count.
  AST_DISABLED_HOLDS: assert property (@(posedge clock) disable iff (!reset_n)
    (!ctrl.enable[0] && !wr.load_wr[0]) |=> $stable(s.cnt[0]))
    else $error("Disabled half kept counting.");

  // A stalled first half holds its count through debug.
  AST_DEBUG_STALL: assert property (@(posedge clock) disable iff (!reset_n)
    (ctrl.halt_in_debug[0] && debug_halted && !wr.load_wr[0] && s.en_prev[0])
      |=> $stable(s.cnt[0]))
    else $error("Counter moved while stalled in debug.");

  // Trigger output stays quiet while its enable is off.
  AST_TRIG_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    !ctrl.trigger_out_on[0] |=> !trigger_out[0])
    else $error("Trigger produced while disabled.");

  // Load write on a running first half reaches the counter next cycle.
  AST_RELOAD_NOW: assert property (@(posedge clock) disable iff (!reset_n)
    (ctrl.enable[0] && wr.load_wr[0])
      |=> (s.cnt[0] == load_readback[0])
          && (load_readback[0][15:0] == $past(wr.wdata[15:0])))
    else $error("Running load write did not reach the counter.");

  // A one-shot half that has stayed finished for two cycles running reads zero.
  AST_ONESHOT_STOP: assert property (@(posedge clock) disable iff (!reset_n)
    (s.done[0] && ctrl.enable[0] && !wr.load_wr[0]) [*2] |-> (s.cnt[0] == '0))
    else $error("One-shot timer kept counting after zero.");

  // Outside PWM the output rests at the level given by polarity.
  AST_PWM_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
    (eff_mode(ctrl.global_mode, ctrl.half_mode[1]) != DHT_PWM)
      |=> (pwm_out[1] == $past(ctrl.output_polarity_low[1])))
    else $error("Idle output level does not follow polarity.");

  // The second half's counter and load stay put while the halves are combined.
  AST_SECOND_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
    (ctrl.global_mode != DHT_PAIR) |=> ($stable(s.cnt[1]) && $stable(s.load[1])))
    else $error("Second half moved in combined mode.");

  // Each tick of a running combined clock advances the count by exactly one.
  AST_RTC_STEP: assert property (@(posedge clock) disable iff (!reset_n)
    ((ctrl.global_mode == DHT_W32_RTC) && ctrl.enable[0] && s.en_prev[0] && ctrl.rtc_enable
     && rtc_tick && !wr.load_wr[0] && !s.done[0] && !(ctrl.halt_in_debug[0] && debug_halted))
      |=> (s.cnt[0] == ($past(s.cnt[0]) + 32'h00000001)))
    else $error("Clock count did not advance on a tick.");

endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the dual half timer: counting, stall, trigger, PWM, status and clear.
// Assumes dht_pkg and dht_timer are compiled first; inputs change on rising edges by NBA.
`timescale 1ns/1ps
module testbench;
  import dht_pkg::*;

  logic                          clock = 1'b0;
  logic                          reset_n;
  dht_ctrl_type                  ctrl;
  dht_write_type                 wr;
  logic                          debug_halted;
  logic [1:0]                    cap_in;
  logic                          rtc_tick;
  logic                          irq;
  logic [IRQ_COUNT-1:0]          status_view;
  logic [1:0][31:0]              timer_value;
  logic [1:0][31:0]              load_readback;
  logic [1:0]                    pwm_out;
  logic [1:0]                    trigger_out;
  int                            mismatches = 0;
  int                            tests_run = 0;
  int                            cycles = 0;
  int                            pulses;
  logic [31:0]                   v;
  logic [31:0]                   d;

  dht_timer i_dht_timer (
    .clock         (clock),
    .reset_n       (reset_n),
    .ctrl          (ctrl),
    .wr            (wr),
    .debug_halted  (debug_halted),
    .cap_in        (cap_in),
    .rtc_tick      (rtc_tick),
    .irq           (irq),
    .status_view   (status_view),
    .timer_value   (timer_value),
    .load_readback (load_readback),
    .pwm_out       (pwm_out),
    .trigger_out   (trigger_out)
  );

  // Free-running 50 MHz clock.
  always #10 clock = ~clock;

  // Compares one value; case inequality so an unknown never counts as a match.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits n rising edges, then moves to the falling edge where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // One-cycle write strobe: kind 0 load, 1 match, 2 clear with mask in the low data bits.
  task automatic write(input int kind, input int h, input logic [31:0] data);
    @(posedge clock);
    wr.wdata <= data;
    wr.irq_source_mask <= data[IRQ_COUNT-1:0];
    if (kind == 0) wr.load_wr <= 2'h1 << h;
    else if (kind == 1) wr.match_wr <= 2'h1 << h;
    else wr.clear_wr <= 1'b1;
    @(posedge clock);
    wr.load_wr <= '0;
    wr.match_wr <= '0;
    wr.clear_wr <= 1'b0;
    @(negedge clock);
  endtask

  // PWM level expected from the frozen count, the threshold and the polarity setting.
  function automatic logic pwm_exp(input logic [31:0] c, input logic [31:0] m, input logic p);
    return (c[15:0] > m[15:0]) ^ p;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // Main sequence; the capture and tick inputs move only in their own scenarios.
  initial
  begin
    ctrl = '0;
    wr = '0;
    debug_halted = 1'b0;
    cap_in = '0;
    rtc_tick = 1'b0;
    reset_n = 1'b0;
    void'($urandom(51205));
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("irq", 32'h0, irq);
    chk("status_view", 32'h0, status_view);
    chk("trigger_out", 32'h0, trigger_out);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      write(0, i % 2, d);
      chk("load_readback", d & HALF_MASK, load_readback[i % 2]);
      chk("timer_value", 32'h0, timer_value[i % 2]);
    end
    // Periodic run twice, trigger off then on; the count must never exceed the load.
    for (int t = 0; t < 2; t++)
    begin
      @(posedge clock);
      ctrl.half_mode[0] <= DHT_PERIODIC;
      ctrl.trigger_out_on[0] <= t[0];
      write(0, 0, 32'h4);
      @(posedge clock);
      ctrl.enable[0] <= 1'b1;
      settle(1);
      chk("timer_value", 32'h4, timer_value[0]);
      pulses = 0;
      v = 32'h0;
      repeat (14)
      begin
        @(negedge clock);
        if (trigger_out[0] === 1'b1) pulses++;
        if (timer_value[0] > 32'h4) v = 32'h1;
      end
      chk("count bound", 32'h0, v);
      chk("trigger seen", t, pulses > 0);
      @(posedge clock);
      ctrl.enable[0] <= 1'b0;
    end
    settle(2);
    chk("raw status", 32'h01, status_view);
    @(posedge clock);
    ctrl.irq_enable <= 7'h7E;
    settle(0);
    chk("irq masked", 32'h0, irq);
    @(posedge clock);
    ctrl.irq_enable <= 7'h01;
    ctrl.masked_view_select <= 1'b1;
    settle(2);
    chk("irq", 32'h1, irq);
    chk("masked view", 32'h01, status_view);
    v = timer_value[0];
    settle(3);
    chk("disabled frozen", v, timer_value[0]);
    write(2, 0, 32'h7E);
    settle(2);
    chk("clear others", 32'h01, status_view);
    write(2, 0, 32'h01);
    settle(2);
    chk("cleared", 32'h0, status_view);
    chk("irq cleared", 32'h0, irq);
    // Debug stall: frozen while stalled, counting when stall is off.
    @(posedge clock);
    ctrl.halt_in_debug[0] <= 1'b1;
    write(0, 0, 32'h100);
    @(posedge clock);
    ctrl.enable[0] <= 1'b1;
    debug_halted <= 1'b1;
    settle(3);
    v = timer_value[0];
    settle(3);
    chk("stalled", v, timer_value[0]);
    @(posedge clock);
    ctrl.halt_in_debug[0] <= 1'b0;
    settle(2);
    chk("runs in debug", 32'h1, timer_value[0] != v);
    d = $urandom;
    write(0, 0, d);
    chk("reload at once", d & HALF_MASK, timer_value[0]);
    // PWM with the counter held by the stall, both thresholds and both polarities.
    @(posedge clock);
    ctrl.enable[0] <= 1'b0;
    @(posedge clock);
    ctrl.half_mode[0] <= DHT_PWM;
    ctrl.halt_in_debug[0] <= 1'b1;
    @(posedge clock);
    ctrl.enable[0] <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      d = k[1] ? 32'hFFFF : 32'h0;
      write(1, 0, d);
      @(posedge clock);
      ctrl.output_polarity_low[0] <= k[0];
      settle(3);
      v = timer_value[0];
      chk("pwm_out", pwm_exp(v, d, k[0]), pwm_out[0]);
    end
    // Combined mode: second half writes are ignored, first half holds all 32 bits.
    @(posedge clock);
    ctrl.enable[0] <= 1'b0;
    debug_halted <= 1'b0;
    @(posedge clock);
    ctrl.global_mode <= DHT_W32_PER;
    settle(1);
    v = load_readback[1];
    write(0, 1, $urandom);
    chk("second half ignored", v, load_readback[1]);
    d = $urandom;
    write(0, 0, d);
    chk("wide load", d, load_readback[0]);
    // Combined one-shot: stops at zero and stays there.
    @(posedge clock);
    ctrl.global_mode <= DHT_W32_OS;
    write(0, 0, 32'h3);
    @(posedge clock);
    ctrl.enable[0] <= 1'b1;
    settle(12);
    chk("one-shot stop", 32'h0, timer_value[0]);
    settle(1);
    chk("one-shot hold", 32'h0, timer_value[0]);
    chk("one-shot irq", 32'h1, irq);
    write(2, 0, 32'h7F);
    chk("irq cleared all", 32'h0, irq);
    // Capture modes on both halves, raw view: event on each edge, match after two edges.
    @(posedge clock);
    ctrl.enable[0] <= 1'b0;
    @(posedge clock);
    ctrl.global_mode <= DHT_PAIR;
    ctrl.half_mode[0] <= DHT_CAP_TIME;
    ctrl.half_mode[1] <= DHT_CAP_COUNT;
    ctrl.irq_enable <= 7'h24;
    ctrl.masked_view_select <= 1'b0;
    write(0, 1, 32'h5);
    write(1, 1, 32'h3);
    @(posedge clock);
    ctrl.enable <= 2'h3;
    repeat (2)
    begin
      @(posedge clock);
      cap_in <= 2'h3;
      @(posedge clock);
      cap_in <= 2'h0;
    end
    settle(1);
    chk("capture count", 32'h3, timer_value[1]);
    chk("capture status", 32'h24, status_view);
    // Combined clock: counts ticks up from the load value and flags the match.
    @(posedge clock);
    ctrl.enable <= 2'h0;
    @(posedge clock);
    ctrl.global_mode <= DHT_W32_RTC;
    ctrl.rtc_enable <= 1'b1;
    write(1, 0, 32'h5);
    @(posedge clock);
    ctrl.enable[0] <= 1'b1;
    repeat (2)
    begin
      @(posedge clock);
      rtc_tick <= 1'b1;
      @(posedge clock);
      rtc_tick <= 1'b0;
    end
    settle(1);
    chk("clock count", 32'h5, timer_value[0]);
    chk("clock status", 32'h2C, status_view);
    // Reset in mid-run clears status, loads and the line again.
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("reset status", 32'h0, status_view);
    chk("reset load", 32'h0, load_readback[0]);
    chk("reset irq", 32'h0, irq);
    wrap_up();
  end
endmodule
